// ### hw/rgb_channel_pwm_dimmer.sv
// Purpose: color times brightness pwm dimming for 24 sink outputs
// Assumes: single AHB-Lite slave, whole-word transfers, 250 MHz clock
// Notes: writes are zero wait, reads insert one wait state
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module rgb_channel_pwm_dimmer
  import dimmer_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // analog reference and sinks
  output logic o_max_current_sel,
  output logic [NUM_CH-1:0] o_sink_output
);

  // ----------------------------------------------------------------
  // log curve
  // ----------------------------------------------------------------
  localparam logic [12:0] LOG_BIAS = 13'h0020;

  function automatic logic [7:0] log_curve(input logic [7:0] b);
    logic [12:0] lin;
    logic [12:0] expo;
    lin = 13'({1'b1, b[4:0]}) << b[7:5];
    expo = lin - LOG_BIAS;
    return (b == BRIGHT_RST) ? BRIGHT_RST : expo[12:5];
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  bus_state_t bus_q;
  logic [7:0] addr_q;
  logic wr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic acc;

  ctrl_t ctrl_q;
  logic [NUM_MOD-1:0] follow_q;
  logic [7:0] bank_bright_q;
  logic [7:0] bank_color_q [NUM_BANK];
  logic [7:0] mod_bright_q [NUM_MOD];
  logic [7:0] color_q [NUM_CH];
  status_t status;

  assign acc = i_hsel && i_htrans[1] && i_hready;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= acc && i_hwrite;
      if (acc) begin
        addr_q <= i_haddr[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (acc && !i_hwrite) begin
            bus_q <= BUS_RDWAIT;
          end
        end
        BUS_RDWAIT: bus_q <= BUS_IDLE;
      endcase
    end
  end

  // read data is taken after any write of the previous data phase landed
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (bus_q == BUS_RDWAIT) begin
      hrdata_q <= rd_mux;
    end
  end

  assign o_hreadyout = (bus_q == BUS_IDLE);
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_q && addr_q == OFS_CTRL) begin
      ctrl_q <= ctrl_t'(i_hwdata[3:0]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      follow_q <= FOLLOW_RST;
    end else if (wr_q && addr_q == OFS_FOLLOW) begin
      follow_q <= i_hwdata[NUM_MOD-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bank_bright_q <= BRIGHT_RST;
    end else if (wr_q && addr_q == OFS_BANK_BRIGHT) begin
      bank_bright_q <= i_hwdata[7:0];
    end
  end

  assign o_max_current_sel = ctrl_q.max_current;

  // ----------------------------------------------------------------
  // level registers
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank_reg
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        bank_color_q[b] <= COLOR_RST;
      end else if (wr_q && addr_q == 8'(OFS_BANK_COLOR0 + 4 * b)) begin
        bank_color_q[b] <= i_hwdata[7:0];
      end
    end
  end

  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod_reg
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        mod_bright_q[m] <= BRIGHT_RST;
      end else if (wr_q && addr_q == 8'(OFS_MOD_BRIGHT0 + 4 * m)) begin
        mod_bright_q[m] <= i_hwdata[7:0];
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_color_reg
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        color_q[c] <= COLOR_RST;
      end else if (wr_q && addr_q == 8'(OFS_CH_COLOR0 + 4 * c)) begin
        color_q[c] <= i_hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == OFS_CTRL) begin
      rd_mux = {28'h000_0000, ctrl_q};
    end
    if (addr_q == OFS_FOLLOW) begin
      rd_mux = {24'h00_0000, follow_q};
    end
    if (addr_q == OFS_BANK_BRIGHT) begin
      rd_mux = {24'h00_0000, bank_bright_q};
    end
    if (addr_q == OFS_STATUS) begin
      rd_mux = status;
    end
    for (int b = 0; b < NUM_BANK; b++) begin
      if (addr_q == 8'(OFS_BANK_COLOR0 + 4 * b)) begin
        rd_mux = {24'h00_0000, bank_color_q[b]};
      end
    end
    for (int m = 0; m < NUM_MOD; m++) begin
      if (addr_q == 8'(OFS_MOD_BRIGHT0 + 4 * m)) begin
        rd_mux = {24'h00_0000, mod_bright_q[m]};
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (addr_q == 8'(OFS_CH_COLOR0 + 4 * c)) begin
        rd_mux = {24'h00_0000, color_q[c]};
      end
    end
  end

  // ----------------------------------------------------------------
  // pwm timebase
  // ----------------------------------------------------------------
  logic [4:0] step_q;
  logic [8:0] pos_q;
  logic [2:0] frame_q;
  logic tick;
  logic wrap;

  assign tick = (step_q == STEP_LAST);
  assign wrap = tick && (pos_q == POS_LAST);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_q <= 5'h00;
    end else begin
      step_q <= tick ? 5'h00 : step_q + 5'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_q <= 9'h000;
    end else if (tick) begin
      pos_q <= pos_q + 9'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_q <= 3'h0;
    end else if (wrap) begin
      frame_q <= frame_q + 3'h1;
    end
  end

  assign status = '{rsvd_hi: 13'h0000, frame: frame_q, rsvd_mid: 3'h0, pos: pos_q,
                    rsvd_lo: 2'h0, any_on: |o_sink_output, running: ctrl_q.chip_run};

  // ----------------------------------------------------------------
  // brightness scaling, index NUM_MOD is the bank
  // ----------------------------------------------------------------
  logic [7:0] scaled [NUM_MOD+1];

  for (genvar m = 0; m <= NUM_MOD; m++) begin : g_scale
    logic [7:0] raw;
    assign raw = (m == NUM_MOD) ? bank_bright_q : mod_bright_q[m % NUM_MOD];
    assign scaled[m] = ctrl_q.log_scale ? log_curve(raw) : raw;
  end

  // ----------------------------------------------------------------
  // per-channel duty and pulse slices
  // ----------------------------------------------------------------
  logic [11:0] duty [NUM_CH];
  logic [9:0] width [NUM_CH];
  logic [2:0] frame_rev;

  // bit-reversed frame spreads the stretched periods evenly
  assign frame_rev = {frame_q[0], frame_q[1], frame_q[2]};

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int unsigned MOD = c / 3;
    localparam int unsigned POSN = c % 3;
    localparam align_t ALIGN = (POSN == 0) ? ALIGN_LEAD :
                               (POSN == 1) ? ALIGN_CENTRE : ALIGN_TRAIL;
    logic [7:0] col;
    logic [7:0] brt;
    logic [15:0] prod;
    logic stretch;

    assign col = follow_q[MOD] ? bank_color_q[POSN] : color_q[c];
    assign brt = follow_q[MOD] ? scaled[NUM_MOD] : scaled[MOD];
    assign prod = 16'(col) * 16'(brt);
    assign duty[c] = prod[15:4];
    assign stretch = ctrl_q.dither_en && (frame_rev < duty[c][2:0]);
    assign width[c] = {1'b0, duty[c][11:3]} + {9'h000, stretch};

    pwm_slice #(
      .ALIGN(ALIGN)
    ) u_slice (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_load(wrap),
      .i_pos(pos_q),
      .i_width(width[c]),
      .i_run(ctrl_q.chip_run),
      .o_sink(o_sink_output[c])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  duty_product_a: assert property (
    !follow_q[0] && !ctrl_q.log_scale |->
      duty[1] == 12'((16'(color_q[1]) * 16'(mod_bright_q[0])) >> 4))
    else $error("channel duty is not color times brightness");

  bank_select_a: assert property (
    follow_q[7] && !ctrl_q.log_scale |->
      duty[23] == 12'((16'(bank_color_q[2]) * 16'(bank_bright_q)) >> 4))
    else $error("bank mode duty uses wrong levels");

  log_ends_a: assert property (
    ctrl_q.log_scale && !follow_q[0] && mod_bright_q[0] == 8'hFF && color_q[0] == 8'hFF
      |-> duty[0] == 12'hFE0)
    else $error("log curve top not full scale");

  log_zero_a: assert property (
    ctrl_q.log_scale && mod_bright_q[2] == 8'h00 |-> scaled[2] == 8'h00)
    else $error("log curve zero not zero");

  dither_off_a: assert property (
    !ctrl_q.dither_en |-> width[4] == {1'b0, duty[4][11:3]})
    else $error("dither active while disabled");

  dither_full_a: assert property (
    ctrl_q.dither_en && duty[3][2:0] == 3'h7 && frame_q != 3'h7 |->
      width[3] == {1'b0, duty[3][11:3]} + 10'h001)
    else $error("dither seven did not stretch");

  stop_sinks_a: assert property (
    !ctrl_q.chip_run |=> o_sink_output == 24'h00_0000)
    else $error("sink on while chip run is low");

  step_rate_a: assert property (
    tick |=> (!tick) [*4] ##0 (step_q == 5'h03))
    else $error("pwm step spacing wrong");

  read_wait_a: assert property (
    acc && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state length wrong");

  bank_on_c: cover property (follow_q[7] && o_sink_output[23]);
  dither_wrap_c: cover property (ctrl_q.dither_en && wrap && frame_q == 3'h7);
  read_done_c: cover property (bus_q == BUS_RDWAIT ##1 o_hreadyout);
  all_on_c: cover property (o_sink_output == 24'hFF_FFFF);

endmodule

// ### common/dimmer_pkg.sv
// Purpose: shared constants and types for the rgb channel pwm dimmer
// Assumes: 250 MHz clock, 24 sink outputs in 8 rgb modules
// Notes: byte offsets are for a 256-byte AHB-Lite slave window
package dimmer_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_MOD = 8;
  localparam int unsigned NUM_CH = 24;
  localparam int unsigned NUM_BANK = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PWM_FREQ_HZ = 29_000;
  localparam int unsigned PWM_STEPS = 512;
  // clock cycles per pwm counter step, rounded to nearest
  localparam int unsigned STEP_CYCLES =
    (CLK_HZ + (PWM_FREQ_HZ * PWM_STEPS) / 2) / (PWM_FREQ_HZ * PWM_STEPS);
  localparam logic [4:0] STEP_LAST = 5'(STEP_CYCLES - 1);
  localparam logic [8:0] POS_LAST = 9'(PWM_STEPS - 1);
  localparam logic [9:0] PWM_TOP = 10'(PWM_STEPS);

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FOLLOW = 8'h04;
  localparam logic [7:0] OFS_BANK_BRIGHT = 8'h08;
  localparam logic [7:0] OFS_BANK_COLOR0 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MOD_BRIGHT0 = 8'h20;
  localparam logic [7:0] OFS_CH_COLOR0 = 8'h40;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic max_current;
    logic dither_en;
    logic log_scale;
    logic chip_run;
  } ctrl_t;

  typedef struct packed {
    logic [12:0] rsvd_hi;
    logic [2:0] frame;
    logic [2:0] rsvd_mid;
    logic [8:0] pos;
    logic [1:0] rsvd_lo;
    logic any_on;
    logic running;
  } status_t;

  localparam ctrl_t CTRL_RST = 4'h6;
  localparam logic [7:0] FOLLOW_RST = 8'h00;
  localparam logic [7:0] BRIGHT_RST = 8'hFF;
  localparam logic [7:0] COLOR_RST = 8'h00;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALIGN_LEAD = 3'b001,
    ALIGN_CENTRE = 3'b010,
    ALIGN_TRAIL = 3'b100
  } align_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RDWAIT = 2'b10
  } bus_state_t;

endpackage

// ### hw/pwm_slice.sv
// Purpose: one sink output pulse generator with selectable alignment
// Assumes: width is latched at the period wrap so pulses never tear
// Notes: width 0 keeps the sink off, width 512 keeps it on all period
`timescale 1ns/1ps
module pwm_slice
  import dimmer_pkg::*;
#(
  parameter align_t ALIGN = ALIGN_LEAD
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // period timing
  input wire logic i_load,
  input wire logic [8:0] i_pos,
  // pulse request
  input wire logic [9:0] i_width,
  input wire logic i_run,
  // sink drive
  output logic o_sink
);

  logic [9:0] width_q;
  logic sink_q;
  logic [9:0] start;
  logic on;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      width_q <= 10'h000;
    end else if (i_load) begin
      width_q <= i_width;
    end
  end

  always_comb begin
    start = (PWM_TOP - width_q) >> 1;
    on = 1'b0;
    unique case (ALIGN)
      ALIGN_LEAD: on = {1'b0, i_pos} < width_q;
      ALIGN_CENTRE: on = ({1'b0, i_pos} >= start) && ({1'b0, i_pos} < start + width_q);
      ALIGN_TRAIL: on = {1'b0, i_pos} >= PWM_TOP - width_q;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sink_q <= 1'b0;
    end else begin
      sink_q <= i_run && on;
    end
  end

  assign o_sink = sink_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  if (ALIGN == ALIGN_LEAD) begin : g_lead_chk
    lead_start_a: assert property (
      i_run && i_pos == 9'h000 && width_q != 10'h000 && !i_load |=> o_sink)
      else $error("leading pulse not on at period start");
  end
  if (ALIGN == ALIGN_TRAIL) begin : g_trail_chk
    trail_end_a: assert property (
      i_run && i_pos == POS_LAST && width_q != 10'h000 && !i_load |=> o_sink)
      else $error("trailing pulse not on at period end");
  end
  if (ALIGN == ALIGN_CENTRE) begin : g_centre_chk
    centre_mid_a: assert property (
      i_run && i_pos == 9'h100 && width_q >= 10'h002 && !i_load |=> o_sink)
      else $error("centred pulse not on at period middle");
  end

endmodule

// ### tb/led_load_model.sv
// Purpose: rgb led load on the sink outputs, notes on-time and edges
// Assumes: one sample per clock, sink on when high
// Notes: on-time is summed while the window is open, edges are always noted
`timescale 1ns/1ps
module led_load_model
  import dimmer_pkg::*;
(
  // clock and window
  input wire logic i_mclk,
  input wire logic i_count_en,
  // sink drive
  input wire logic [NUM_CH-1:0] i_sink_output,
  // what the leds saw
  output int unsigned o_on_cnt [NUM_CH],
  output int unsigned o_rise_t [NUM_CH],
  output int unsigned o_fall_t [NUM_CH]
);
  int unsigned cyc = 0;
  logic en_q = 1'b0;
  logic [NUM_CH-1:0] prev_q = '0;

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    en_q <= i_count_en;
    prev_q <= i_sink_output;
    for (int i = 0; i < NUM_CH; i++) begin
      // a fresh window starts from zero
      if (i_count_en) o_on_cnt[i] <= (en_q ? o_on_cnt[i] : 0) + 32'(i_sink_output[i]);
      if (i_sink_output[i] && !prev_q[i]) o_rise_t[i] <= cyc;
      if (!i_sink_output[i] && prev_q[i]) o_fall_t[i] <= cyc;
    end
  end
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench for the rgb channel pwm dimmer
// Assumes: ahb-lite master with single word transfers, led load model
// Notes: on-time windows of one and eight periods keep the run short
`timescale 1ns/1ps
module tb_top
  import dimmer_pkg::*;
();
  localparam int PER = STEP_CYCLES * PWM_STEPS;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic max_sel;
  wire logic [NUM_CH-1:0] sinks;
  logic en = 1'b0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] col [NUM_CH];
  logic [7:0] mb [NUM_MOD];
  logic [7:0] bc [NUM_BANK];
  logic [7:0] bb;
  logic [7:0] fol;
  int unsigned on_cnt [NUM_CH];
  int unsigned rise_t [NUM_CH];
  int unsigned fall_t [NUM_CH];

  always #2 i_mclk = ~i_mclk;

  rgb_channel_pwm_dimmer i_dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .o_max_current_sel(max_sel), .o_sink_output(sinks)
  );

  led_load_model i_load (
    .i_mclk(i_mclk), .i_count_en(en), .i_sink_output(sinks),
    .o_on_cnt(on_cnt), .o_rise_t(rise_t), .o_fall_t(fall_t)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // a read ends at the first edge with hready high after its address phase
  always @(posedge i_mclk) begin
    if (rd_pend && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check({31'h00000000, hresp}, 32'h00000000);
    end
    if (hready === 1'b1) begin
      rd_pend <= hsel && htrans[1] && !hwrite;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_mclk);
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  // hready is read at the rising edge, before that edge updates the slave
  task automatic wait_rdy();
    do begin
      @(posedge i_mclk);
    end while (hready !== 1'b1);
  endtask

  task automatic addr_phase(input logic [7:0] a, input logic w);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_phase(a, 1'b0);
    exp_q.push_back(e);
    wait_rdy();
  endtask

  // ----------------------------------------------------------------
  // led on-time
  // ----------------------------------------------------------------
  function automatic int unsigned on_time(input int i, input bit dith);
    int unsigned c;
    int unsigned b;
    int unsigned d;
    c = fol[i/3] ? bc[i%3] : col[i];
    b = fol[i/3] ? bb : mb[i/3];
    d = (c * b) >> 4;
    return dith ? d * STEP_CYCLES : (d >> 3) * STEP_CYCLES;
  endfunction

  task automatic measure(input int n);
    repeat (PER + 40) @(posedge i_mclk);
    en <= 1'b1;
    repeat (n * PER) @(posedge i_mclk);
    en <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic load_levels();
    for (int i = 0; i < NUM_CH; i++) wr(OFS_CH_COLOR0 + 8'(4 * i), {24'h000000, col[i]});
    for (int k = 0; k < NUM_MOD; k++) wr(OFS_MOD_BRIGHT0 + 8'(4 * k), {24'h000000, mb[k]});
    for (int k = 0; k < NUM_BANK; k++) wr(OFS_BANK_COLOR0 + 8'(4 * k), {24'h000000, bc[k]});
    wr(OFS_BANK_BRIGHT, {24'h000000, bb});
    wr(OFS_FOLLOW, {24'h000000, fol});
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h01FC8F37));
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // reset values, reserved bits, unmapped place
    rd(OFS_CTRL, 32'h00000006);
    rd(OFS_FOLLOW, 32'h00000000);
    rd(OFS_BANK_BRIGHT, 32'h000000FF);
    for (int k = 0; k < NUM_MOD; k++) rd(OFS_MOD_BRIGHT0 + 8'(4 * k), 32'h000000FF);
    rd(OFS_CH_COLOR0 + 8'h5C, 32'h00000000);
    wr(OFS_MOD_BRIGHT0, 32'h000001A5);
    rd(OFS_MOD_BRIGHT0, 32'h000000A5);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h00000000);
    wr(OFS_CTRL, 32'hFFFFFFF8);
    rd(OFS_CTRL, 32'h00000008);
    @(negedge i_mclk);
    check({31'h00000000, max_sel}, 32'h00000001);
    wr(OFS_CTRL, 32'h00000001);
    @(negedge i_mclk);
    check({31'h00000000, max_sel}, 32'h00000000);
    $display("registers done");
    // linear, no dither, module 7 follows the bank
    for (int i = 0; i < NUM_CH; i++) col[i] = 8'($urandom);
    for (int k = 0; k < NUM_MOD; k++) mb[k] = 8'($urandom);
    for (int k = 0; k < NUM_BANK; k++) bc[k] = 8'($urandom);
    bb = 8'($urandom);
    fol = 8'h80;
    load_levels();
    measure(1);
    for (int i = 0; i < NUM_CH; i++) check(on_cnt[i], on_time(i, 1'b0));
    $display("linear done");
    // log and dither on, module 1 follows, module 2 dark, module 0 aligned
    wr(OFS_CTRL, 32'h00000007);
    for (int i = 0; i < 3; i++) col[i] = 8'h80;
    col[0] = 8'hFF;
    bc[0] = 8'h01;
    for (int k = 0; k < NUM_MOD; k++) mb[k] = 8'hFF;
    mb[2] = 8'h00;
    bb = 8'hFF;
    fol = 8'h02;
    load_levels();
    measure(8);
    for (int i = 0; i < NUM_CH; i++) check(on_cnt[i], on_time(i, 1'b1));
    check(fall_t[2], rise_t[0]);
    check((rise_t[1] + 8 * PER - rise_t[0]) % PER, 128 * STEP_CYCLES);
    check((fall_t[0] + 8 * PER - rise_t[0]) % PER, ((255 * 255) >> 7) * STEP_CYCLES);
    $display("dither done");
    // chip run low turns every sink off, levels stay readable
    wr(OFS_CTRL, 32'h00000006);
    @(posedge i_mclk);
    @(negedge i_mclk);
    check({8'h00, sinks}, 32'h00000000);
    rd(OFS_CH_COLOR0 + 8'h14, {24'h000000, col[5]});
    wr(OFS_BANK_BRIGHT, 32'h0000005A);
    rd(OFS_BANK_BRIGHT, 32'h0000005A);
    $display("standby done");
    tally_and_finish();
  end
endmodule
